//--- common/afc_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef AFC_DEFINES_SVH
`define AFC_DEFINES_SVH

// Register byte offsets
`define AFC_REG_CFG 4'h0
`define AFC_REG_STATUS 4'h4
`define AFC_REG_DATA 4'h8

// Configuration register fields
`define AFC_CFG_SEL_LSB 0
`define AFC_CFG_GAIN_LSB 4
`define AFC_CFG_BYPASS_BIT 7
`define AFC_CFG_REF_LSB 8
`define AFC_CFG_TURBO_BIT 10
`define AFC_CFG_RATE_LSB 12

// Status register fields
`define AFC_ST_CAPGAIN_LSB 0
`define AFC_ST_AMPGAIN_LSB 2
`define AFC_ST_AMPEN_BIT 5
`define AFC_ST_NEGTIE_BIT 6
`define AFC_ST_DATAVALID_BIT 7
`define AFC_ST_OVERRUN_BIT 8
`define AFC_ST_REFSETTLED_BIT 9

// Reset values
`define AFC_CFG_RESET 32'h0000_0000

// Clock and oscillator figures
`define AFC_MCLK_HZ 64'd25000000
`define AFC_OSC_NORMAL_HZ 64'd1024000
`define AFC_OSC_TURBO_HZ 64'd2048000
`define AFC_PHASE_BITS 24
`define AFC_MOD_DIV 4
`define AFC_INC_NORMAL ((`AFC_OSC_NORMAL_HZ << `AFC_PHASE_BITS) / `AFC_MCLK_HZ)
`define AFC_INC_TURBO ((`AFC_OSC_TURBO_HZ << `AFC_PHASE_BITS) / `AFC_MCLK_HZ)

// Internal reference settling, least time rounded up
`define AFC_MCLK_PERIOD_NS 40
`define AFC_REF_SETTLE_NS 25000
`define AFC_REF_SETTLE_CYC \
    ((`AFC_REF_SETTLE_NS + `AFC_MCLK_PERIOD_NS - 1) / `AFC_MCLK_PERIOD_NS)

// Decimation lengths in modulator clocks per data-rate code
`define AFC_OSR_0 16'd12798
`define AFC_OSR_1 16'd5695
`define AFC_OSR_2 16'd2883
`define AFC_OSR_3 16'd1479
`define AFC_OSR_4 16'd779
`define AFC_OSR_5 16'd431
`define AFC_OSR_6 16'd259

`endif

//--- common/afc_pkg.sv
// Types shared by the converter front-end control logic
`default_nettype none
package afc_pkg;
    typedef enum logic [1:0] {
        AFC_REF_INTERNAL = 2'h0,
        AFC_REF_EXTERNAL = 2'h1,
        AFC_REF_SUPPLY = 2'h2,
        AFC_REF_SUPPLY_ALT = 2'h3
    } afc_ref_e;

    typedef struct packed {
        logic [2:0] rate;
        logic turbo;
        afc_ref_e refSelect;
        logic ampBypassRequest;
        logic [2:0] gain;
        logic [3:0] inputSelect;
    } afc_cfg_s;

    typedef struct packed {
        logic ampEnable;
        logic negInputToSupply;
        logic [2:0] ampGain;
        logic [1:0] capGain;
    } afc_ana_s;
endpackage
`default_nettype wire

//--- hdl/afc_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module afc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstSync_n,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0] level;
    } fifo_s;

    fifo_s st_r;
    fifo_s st_nxt;
    logic doPush;
    logic doPop;

    assign inReady = (st_r.level != (AW+1)'(DEPTH));
    assign outValid = (st_r.level != '0);
    assign outData = st_r.mem[st_r.rdPtr];
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    always_comb begin
        st_nxt = st_r;
        if (doPush) begin
            st_nxt.mem[st_r.wrPtr] = inData;
            st_nxt.wrPtr = (st_r.wrPtr == AW'(DEPTH - 1)) ? '0 :
                AW'(st_r.wrPtr + 1'b1);
        end
        if (doPop) begin
            st_nxt.rdPtr = (st_r.rdPtr == AW'(DEPTH - 1)) ? '0 :
                AW'(st_r.rdPtr + 1'b1);
        end
        if (doPush && !doPop) begin
            st_nxt.level = (AW+1)'(st_r.level + 1'b1);
        end else if (doPop && !doPush) begin
            st_nxt.level = (AW+1)'(st_r.level - 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

//--- hdl/afc_frontend.sv
// Converter front-end control: gain/bypass decode, reference, clocking, filter
//
// Overview of operation
// [R1] Bypass request with gain 1, 2 or 4 disables and bypasses the amplifier.
// [R2] Input codes 1000 to 1011 tie negative input to negative supply.
// [R3] Input codes 1000 to 1011 force amplifier bypass regardless of request.
// [R4] Single-ended selection clamps effective gain to 4 when programmed above.
// [R5] With amplifier off, gains 1, 2, 4 come from switched-capacitor stage.
// [R6] Two-bit field picks internal, external pair or supply reference.
// [R7] After reset the reference field selects the internal reference.
// [R8] Software waits 25 us for internal reference to settle before use.
// [R9] Modulator clock runs at one quarter of oscillator frequency.
// [R10] Oscillator 1.024 MHz normal, 2.048 MHz turbo; modulator 256/512 kHz.
// [R11] Linear-phase FIR decimates the bitstream, length follows data rate.
// [R12] Filter settles in one conversion; restarts cleanly on config change.
// [R13] Data rate and notches derive from oscillator clock, scaling with it.
// [R14] Input selection held in a four-bit configuration field.
// [R15] Gain held in three-bit field: gains 1 to 128 in powers of two.
// [R16] Bypass request with gain above 4 differential keeps amplifier on.
// [R17] Modulator enable is divide-by-four count, restarted on mode change.
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`include "afc_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module afc_frontend #(
    parameter int FIFO_DEPTH = 16,
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    // Modulator bitstream from the analog core
    input wire logic modBit,
    // Analog controls
    output logic modClkEn,
    output logic ampEnable,
    output logic negInputToSupply,
    output logic [2:0] ampGain,
    output logic [1:0] capGain,
    output logic [1:0] refSelect,
    output logic refSettled
);
    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [1:0] modSync;
        afc_pkg::afc_cfg_s cfg;
        afc_pkg::afc_ana_s ana;
        logic ack;
        logic [31:0] readData;
        logic [`AFC_PHASE_BITS-1:0] phase;
        logic [1:0] oscDiv;
        logic modEn;
        logic [15:0] accum;
        logic [15:0] count;
        logic [DATA_W-1:0] result;
        logic resultValid;
        logic overrun;
        logic [9:0] refTimer;
    } st_s;

    localparam logic [`AFC_PHASE_BITS-1:0] INC_NORMAL =
        `AFC_PHASE_BITS'(`AFC_INC_NORMAL);
    localparam logic [`AFC_PHASE_BITS-1:0] INC_TURBO =
        `AFC_PHASE_BITS'(`AFC_INC_TURBO);
    localparam logic [9:0] REF_SETTLE = 10'(`AFC_REF_SETTLE_CYC);

    st_s st_r;
    st_s st_nxt;
    logic [1:0] rstPipe_r;
    logic rstSync_n;
    logic fifoInReady;
    logic fifoOutValid;
    logic [DATA_W-1:0] fifoOutData;
    logic fifoPop;
    logic busReq;
    logic busAck;

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    function automatic afc_pkg::afc_ana_s decodeGain(
        input afc_pkg::afc_cfg_s c
    );
        afc_pkg::afc_ana_s a;
        logic singleEnded;
        logic lowGain;
        singleEnded = (c.inputSelect[3:2] == 2'h2); // [R2] [R3]
        lowGain = (c.gain <= 3'h2);
        a.negInputToSupply = singleEnded; // [R2]
        // Bypass only honoured for low gains; otherwise amplifier stays on unless input is single-ended
        a.ampEnable = !(singleEnded || (c.ampBypassRequest && lowGain));
        // [R1] [R3] [R16]
        if (lowGain) begin
            a.ampGain = 3'h0; // [R5]
            a.capGain = c.gain[1:0];
        end else if (singleEnded) begin
            a.ampGain = 3'h0; // [R4]
            a.capGain = 2'h2;
        end else begin
            a.ampGain = 3'(c.gain - 3'h2); // [R16]
            a.capGain = 2'h2;
        end
        return a;
    endfunction

    function automatic logic [15:0] rateToOsr(input logic [2:0] rate);
        logic [15:0] osr;
        osr = `AFC_OSR_6;
        unique case (rate)
            3'h0: osr = `AFC_OSR_0;
            3'h1: osr = `AFC_OSR_1;
            3'h2: osr = `AFC_OSR_2;
            3'h3: osr = `AFC_OSR_3;
            3'h4: osr = `AFC_OSR_4;
            3'h5: osr = `AFC_OSR_5;
            3'h6: osr = `AFC_OSR_6;
            3'h7: osr = `AFC_OSR_6;
        endcase
        return osr;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset release

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_r <= 2'h0;
        end else begin
            rstPipe_r <= {rstPipe_r[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe_r[1];

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle on every access

    assign busReq = avsRead || avsWrite;
    assign busAck = busReq && st_r.ack;
    assign avsWaitrequest = busReq && !st_r.ack;
    assign avsReaddata = st_r.readData;
    assign fifoPop = busAck && avsRead && (avsAddress == `AFC_REG_DATA);

    ////////////////////////////////////////////////////////////////////////
    // Output data FIFO

    afc_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rstSync_n(rstSync_n),
        .inValid(st_r.resultValid),
        .inReady(fifoInReady),
        .inData(st_r.result),
        .outValid(fifoOutValid),
        .outReady(fifoPop),
        .outData(fifoOutData)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic cfgWrite;
        logic overrunClr;
        logic [`AFC_PHASE_BITS:0] phaseSum;
        logic oscTick;
        logic modBitNow;
        logic [15:0] osr;
        logic newResult;
        afc_pkg::afc_cfg_s newCfg;

        cfgWrite = 1'b0;
        overrunClr = 1'b0;
        phaseSum = '0;
        oscTick = 1'b0;
        modBitNow = 1'b0;
        osr = '0;
        newResult = 1'b0;
        newCfg = st_r.cfg;
        st_nxt = st_r;

        // Bitstream comes from the analog side: synchronise first
        st_nxt.modSync = {st_r.modSync[0], modBit};
        modBitNow = st_r.modSync[1];

        // Register access
        st_nxt.ack = busReq && !st_r.ack;
        if (busReq && !st_r.ack) begin
            st_nxt.readData = 32'h0;
            unique case (avsAddress)
                `AFC_REG_CFG: begin
                    // Field by field: packed struct order leaves no bit 11
                    st_nxt.readData[`AFC_CFG_SEL_LSB +: 4] =
                        st_r.cfg.inputSelect; // [R14]
                    st_nxt.readData[`AFC_CFG_GAIN_LSB +: 3] = st_r.cfg.gain;
                    st_nxt.readData[`AFC_CFG_BYPASS_BIT] =
                        st_r.cfg.ampBypassRequest;
                    st_nxt.readData[`AFC_CFG_REF_LSB +: 2] =
                        st_r.cfg.refSelect;
                    st_nxt.readData[`AFC_CFG_TURBO_BIT] = st_r.cfg.turbo;
                    st_nxt.readData[`AFC_CFG_RATE_LSB +: 3] = st_r.cfg.rate;
                end
                `AFC_REG_STATUS: begin
                    st_nxt.readData[`AFC_ST_CAPGAIN_LSB +: 2] =
                        st_r.ana.capGain;
                    st_nxt.readData[`AFC_ST_AMPGAIN_LSB +: 3] =
                        st_r.ana.ampGain;
                    st_nxt.readData[`AFC_ST_AMPEN_BIT] = st_r.ana.ampEnable;
                    st_nxt.readData[`AFC_ST_NEGTIE_BIT] =
                        st_r.ana.negInputToSupply;
                    st_nxt.readData[`AFC_ST_DATAVALID_BIT] = fifoOutValid;
                    st_nxt.readData[`AFC_ST_OVERRUN_BIT] = st_r.overrun;
                    st_nxt.readData[`AFC_ST_REFSETTLED_BIT] =
                        (st_r.refTimer == 10'h0);
                end
                `AFC_REG_DATA: begin
                    st_nxt.readData = 32'(fifoOutData);
                end
                default: begin
                    st_nxt.readData = 32'h0;
                end
            endcase
        end
        if (busAck && avsWrite) begin
            if (avsAddress == `AFC_REG_CFG) begin
                cfgWrite = 1'b1;
                newCfg.inputSelect =
                    avsWritedata[`AFC_CFG_SEL_LSB +: 4]; // [R14]
                newCfg.gain = avsWritedata[`AFC_CFG_GAIN_LSB +: 3]; // [R15]
                newCfg.ampBypassRequest = avsWritedata[`AFC_CFG_BYPASS_BIT];
                newCfg.refSelect = afc_pkg::afc_ref_e'(
                    avsWritedata[`AFC_CFG_REF_LSB +: 2]); // [R6]
                newCfg.turbo = avsWritedata[`AFC_CFG_TURBO_BIT];
                newCfg.rate = avsWritedata[`AFC_CFG_RATE_LSB +: 3];
                st_nxt.cfg = newCfg;
            end
            if (avsAddress == `AFC_REG_STATUS) begin
                overrunClr = avsWritedata[`AFC_ST_OVERRUN_BIT];
            end
        end

        // Registered analog controls follow the stored configuration
        st_nxt.ana = decodeGain(st_r.cfg);

        // Reference settle timer restarts when switching to internal
        if (cfgWrite && newCfg.refSelect == afc_pkg::AFC_REF_INTERNAL &&
            st_r.cfg.refSelect != afc_pkg::AFC_REF_INTERNAL) begin
            st_nxt.refTimer = REF_SETTLE; // [R8]
        end else if (st_r.refTimer != 10'h0) begin
            st_nxt.refTimer = 10'(st_r.refTimer - 10'h1);
        end

        // Oscillator model: phase accumulator at the mode's frequency
        phaseSum = {1'b0, st_r.phase} +
            {1'b0, st_r.cfg.turbo ? INC_TURBO : INC_NORMAL}; // [R10]
        st_nxt.phase = phaseSum[`AFC_PHASE_BITS-1:0];
        oscTick = phaseSum[`AFC_PHASE_BITS];
        st_nxt.modEn = 1'b0;
        if (oscTick) begin
            st_nxt.oscDiv = 2'(st_r.oscDiv + 2'h1);
            st_nxt.modEn = (st_r.oscDiv == 2'(`AFC_MOD_DIV - 1)); // [R9]
        end
        // Mode change restarts the divider so no short modulator cycle
        if (cfgWrite && newCfg.turbo != st_r.cfg.turbo) begin
            st_nxt.phase = '0; // [R17]
            st_nxt.oscDiv = 2'h0; // [R17]
            st_nxt.modEn = 1'b0;
        end

        // Boxcar FIR: equal taps give linear phase, one period to settle
        osr = rateToOsr(st_r.cfg.rate); // [R11] [R13]
        if (st_r.modEn) begin
            if (st_r.count == 16'(osr - 16'h1)) begin
                newResult = 1'b1;
                st_nxt.result = DATA_W'(st_r.accum + {15'h0, modBitNow});
                st_nxt.accum = 16'h0;
                st_nxt.count = 16'h0;
            end else begin
                st_nxt.accum = 16'(st_r.accum + {15'h0, modBitNow});
                st_nxt.count = 16'(st_r.count + 16'h1);
            end
        end
        // Any configuration write discards a partial sum, so the
        // first result after it is already fully settled
        if (cfgWrite) begin
            st_nxt.accum = 16'h0; // [R12]
            st_nxt.count = 16'h0; // [R12]
            newResult = 1'b0;
            st_nxt.result = st_r.result;
        end

        // Hand result to the FIFO; a full FIFO holds it back
        if (st_r.resultValid && fifoInReady) begin
            st_nxt.resultValid = 1'b0;
        end
        if (overrunClr) begin
            st_nxt.overrun = 1'b0;
        end
        if (newResult) begin
            st_nxt.resultValid = 1'b1;
            // Held result would be lost: flag it, set wins over clear
            if (st_r.resultValid && !fifoInReady) begin
                st_nxt.overrun = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            st_r <= '0;
            st_r.cfg <= afc_pkg::afc_cfg_s'(14'(`AFC_CFG_RESET)); // [R7]
            st_r.ana.ampEnable <= 1'b1;
            st_r.refTimer <= REF_SETTLE; // [R8]
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign modClkEn = st_r.modEn;
    assign ampEnable = st_r.ana.ampEnable;
    assign negInputToSupply = st_r.ana.negInputToSupply;
    assign ampGain = st_r.ana.ampGain;
    assign capGain = st_r.ana.capGain;
    assign refSelect = st_r.cfg.refSelect; // [R6]
    assign refSettled = (st_r.refTimer == 10'h0);
endmodule
`default_nettype wire

//--- tb/afc_frontend_checker.sv
// Concurrent checks on the front-end analog control and clock ports
`timescale 1ns/1ns
`default_nettype none
module afc_frontend_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Analog controls
    input wire logic modClkEn,
    input wire logic ampEnable,
    input wire logic negInputToSupply,
    input wire logic [2:0] ampGain,
    input wire logic [1:0] capGain,
    input wire logic [1:0] refSelect,
    input wire logic refSettled
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [7:0] gapCnt_r;
    ////////////////////////////////////////////////////////////////////////
    // Cycles since the last modulator pulse, saturating
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gapCnt_r <= 8'h00;
        end else if (modClkEn) begin
            gapCnt_r <= 8'h01;
        end else if (gapCnt_r != 8'hFF) begin
            gapCnt_r <= gapCnt_r + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_released;
        $rose(rst_n);
    endsequence
    sequence s_ref_default;
        (refSelect == 2'h0 && !refSettled) [*8];
    endsequence
    a_negtie_bypass: assert property (
        negInputToSupply |-> !ampEnable)
        else $error("negative tie with amplifier on");
    a_negtie_clamp: assert property (
        negInputToSupply |-> ampGain == 3'h0 && capGain <= 2'h2)
        else $error("single-ended gain above 4");
    a_ampoff_gain: assert property (
        !ampEnable |-> ampGain == 3'h0)
        else $error("amplifier gain while bypassed");
    a_capgain_range: assert property (
        capGain != 2'h3)
        else $error("switched-cap gain out of range");
    a_ampgain_split: assert property (
        ampGain != 3'h0 |-> capGain == 2'h2 && ampGain <= 3'h5)
        else $error("gain split wrong");
    a_mod_fast: assert property (
        modClkEn |-> gapCnt_r >= 8'd47)
        else $error("modulator pulses too close");
    a_mod_slow: assert property (
        gapCnt_r < 8'd250)
        else $error("modulator pulse missing");
    a_ref_reset: assert property (
        s_released |-> s_ref_default)
        else $error("reference not internal after reset");
    a_ref_hold: assert property (
        $changed(refSelect) && refSelect == 2'h0 |-> !refSettled [*8])
        else $error("reference settled too early");
endmodule
`default_nettype wire

//--- tb/afc_frontend_test.sv
// Self-checking bench for the converter front-end control block
`include "afc_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module afc_frontend_test;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avsAddress = 4'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic modBit = 1'b0;
    logic modClkEn, ampEnable, negInputToSupply, refSettled;
    logic [2:0] ampGain;
    logic [1:0] capGain, refSelect;
    logic [31:0] expQ[$], mskQ[$];
    logic [31:0] rdq, r, d;
    int n_mismatch = 0;
    int checked = 0;
    int seed = 32'haeaa4f6f;
    int n, t, lo;
    always #20 mclk = ~mclk;
    afc_frontend uut (.mclk(mclk), .rst_n(rst_n), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
        .modBit(modBit), .modClkEn(modClkEn), .ampEnable(ampEnable),
        .negInputToSupply(negInputToSupply), .ampGain(ampGain),
        .capGain(capGain), .refSelect(refSelect), .refSettled(refSettled));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Request held until the edge that sees waitrequest low
    task automatic bus(input logic we, input logic [3:0] a,
                       input logic [31:0] wd);
        @(posedge mclk);
        avsAddress <= a;
        avsWritedata <= wd;
        avsWrite <= we;
        avsRead <= !we;
        do @(posedge mclk); while (avsWaitrequest !== 1'b0);
        rdq = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] wd);
        bus(1'b1, a, wd);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] want,
                      input logic [31:0] m);
        expQ.push_back(want);
        mskQ.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wait_data;
        for (int k = 0; k < 8000; k++) begin
            rd(`AFC_REG_STATUS, 32'h0, 32'h0);
            if (rdq[7] === 1'b1) break;
        end
    endtask
    // Expected STATUS[6:0] from select, gain and bypass request
    function automatic logic [31:0] status(input logic [7:0] c);
        logic [2:0] g;
        g = c[6:4];
        if (c[3:2] == 2'b10) begin
            status = {25'h0, 2'b10, 3'h0, (g > 3'h2) ? 2'h2 : g[1:0]};
        end else begin
            status = {25'h0, 1'b0, !(c[7] && g <= 3'h2),
                      (g > 3'h2) ? {g - 3'h2, 2'h2} : {3'h0, g[1:0]}};
        end
    endfunction
    ////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        if (avsRead === 1'b1 && avsWaitrequest === 1'b0 && expQ.size() > 0)
        begin
            check("readdata", avsReaddata & mskQ.pop_front(),
                  expQ.pop_front());
        end
    end
    initial begin
        repeat (90000) @(posedge mclk);
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (10) @(posedge mclk);
        check("refSelect", {30'h0, refSelect}, 32'h0);
        rd(`AFC_REG_CFG, 32'h0, 32'hFFFF_FFFF);
        rd(`AFC_REG_STATUS, 32'h20, 32'h7F);
        // Every select, gain and bypass code; turbo held to keep clocking
        for (n = 0; n < 256; n++) begin
            r = $random(seed);
            d = {r[31:11], 1'b0, r[9:8], n[7:0]};
            modBit <= r[20];
            wr(`AFC_REG_CFG, d);
            rd(`AFC_REG_CFG, d & 32'h0000_77FF, 32'hFFFF_FFFF);
            rd(`AFC_REG_STATUS, status(n[7:0]), 32'h7F);
            check("refSelect", {30'h0, refSelect}, {30'h0, r[9:8]});
        end
        rd(4'hC, 32'h0, 32'hFFFF_FFFF);
        wr(4'hC, 32'hFFFF_FFFF);
        rd(`AFC_REG_CFG, d & 32'h0000_77FF, 32'hFFFF_FFFF);
        // Back to internal reference restarts the settle time
        wr(`AFC_REG_CFG, 32'h0000_0100);
        wr(`AFC_REG_CFG, 32'h0000_0000);
        rd(`AFC_REG_STATUS, 32'h20, 32'h27F);
        repeat (640) @(posedge mclk);
        rd(`AFC_REG_STATUS, 32'h220, 32'h27F);
        // Pulse count over 10000 cycles: 102.4 normal, 204.8 turbo
        for (t = 0; t < 2; t++) begin
            wr(`AFC_REG_CFG, t << 10);
            n = 0;
            repeat (10000) begin
                @(posedge mclk);
                n += (modClkEn === 1'b1);
            end
            lo = t ? 203 : 101;
            check("modPulses", n >= lo && n <= lo + 3, 32'h1);
        end
        // Constant ones, then zeros after restart: no partial sums
        modBit <= 1'b1;
        repeat (4) @(posedge mclk);
        wr(`AFC_REG_CFG, 32'h0000_6400);
        wait_data;
        rd(`AFC_REG_DATA, 32'd259, 32'hFFFF);
        modBit <= 1'b0;
        repeat (4) @(posedge mclk);
        wr(`AFC_REG_CFG, 32'h0000_6400);
        wait_data;
        rd(`AFC_REG_DATA, 32'h0, 32'hFFFF);
        @(posedge mclk);
        report_and_stop;
    end
endmodule
bind afc_frontend afc_frontend_checker chk (.mclk(mclk), .rst_n(rst_n),
    .modClkEn(modClkEn), .ampEnable(ampEnable),
    .negInputToSupply(negInputToSupply), .ampGain(ampGain),
    .capGain(capGain), .refSelect(refSelect), .refSettled(refSettled));
`default_nettype wire
